// file: hw/dcf_fifo.sv
// queue logic on i_clk; both port clocks are sampled pins, edges detected
// assumes port clocks at most one quarter of i_clk
// the queue reset pin is handled like any data pin; the system reset
// only brings the logic to a known state before the pin is sampled
// cascading and its chain pins are not part of this block: the part
// always behaves as a standalone queue with read permission
`timescale 1ns/1ps
module dcf_fifo #(
  parameter int DEPTH = dcf_pkg::DCF_DEPTH,
  parameter int WIDTH = dcf_pkg::DCF_WIDTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_queue_reset_n,
  input  wire logic             i_write_clk,
  input  wire logic             i_read_clk,
  input  wire logic             i_write_en_n,
  input  wire logic             i_read_en_n,
  input  wire logic             i_output_en_n,
  input  wire logic             i_load_select_n,
  input  wire logic             i_retransmit,
  input  wire logic             i_sync_flag_mode,
  input  wire logic [WIDTH-1:0] i_write_data,
  output logic      [WIDTH-1:0] o_read_data,
  output logic      [WIDTH-1:0] o_read_data_oe_n,
  output logic                  o_empty_indicator_n,
  output logic                  o_full_indicator_n,
  output logic                  o_half_full_indicator_n,
  output logic                  o_almost_empty_indicator_n,
  output logic                  o_almost_full_indicator_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = dcf_pkg::DCF_THR_W;
  localparam logic [TW-1:0] THR_DEF = (DEPTH == dcf_pkg::DCF_SMALL_DEP) ?
      TW'(dcf_pkg::DCF_THR_SMALL) : TW'(dcf_pkg::DCF_THR_LARGE);
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] FULLC = (AW+1)'(DEPTH);

  //
  // timing through the block, counted in i_clk edges from a port pin edge
  //   edge 1: pin lands in the first synchroniser flop
  //   edge 2: second flop holds a clean level
  //   edge 3: rise strobe and the aligned control word become valid
  //   edge 4: pointers, output register and flags take their new values
  // enables and data take the same three-flop path, so a level that is
  // steady for one i_clk on either side of the pin edge is seen correctly
  //
  // port clocks faster than a quarter of i_clk would merge two rises into
  // one strobe; the write or read would then be lost without any flag
  //
  // pointers carry one extra bit so that a full queue and an empty one
  // differ; the difference of the two pointers is the occupancy
  //
  // flag decode, by occupancy c:
  //   empty        low when c is zero
  //   almost empty low when c is at or below the empty offset
  //   half full    low when c is above half the depth
  //   almost full  low when c is within the full offset of the depth
  //   full         low when c equals the depth
  //
  // offsets wider than the pointer are cut to pointer width; an offset
  // of twice the depth or more therefore wraps, a limitation the user must know
  // reads of an empty queue and writes to a full one are silently
  // refused; no error flag exists, the flags alone tell the user
  //

  // refuse depths the flag table does not cover
  if (!(DEPTH == 512 || DEPTH == 1024 || DEPTH == 2048 || DEPTH == 4096)) begin : g_bad_depth
    $error("dcf_fifo: DEPTH must be 512, 1024, 2048 or 4096");
  end
  if (WIDTH < TW) begin : g_bad_width
    $error("dcf_fifo: WIDTH must hold a threshold");
  end

  // the storage is a plain array: one write port driven by the write
  // strobe and one read port used by the read strobe, both on i_clk
  // the read is registered into the output word, so data on the pins
  // changes only on a read port edge or in the first cycle of a queue reset
  //
  // storage array, written and read on i_clk
  logic [WIDTH-1:0] mem [DEPTH];

  // one synchroniser per port clock; each gives a single-cycle strobe
  // on the rising edge and the clean level, which is unused here
  // the level is kept on the carrier for a checker or a later
  // falling-edge feature
  dcf_edge_if wr_e ();
  dcf_edge_if rd_e ();
  dcf_edge_sync u_wr_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (i_write_clk),
    .e       (wr_e)
  );
  dcf_edge_sync u_rd_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (i_read_clk),
    .e       (rd_e)
  );

  // every other pin passes three flops; data and enables are delayed to
  // line up with the edge strobe, which also lags by the same depth
  typedef struct packed {
    logic [WIDTH-1:0] d1;
    logic [WIDTH-1:0] d2;
    logic [WIDTH-1:0] d3;
    logic [6:0]       c1;
    logic [6:0]       c2;
    logic [6:0]       c3;
  } dcf_in_t;
  dcf_in_t in_q, next_in_q;

  always_comb begin
    next_in_q    = in_q;
    next_in_q.d1 = i_write_data;
    next_in_q.d2 = in_q.d1;
    next_in_q.d3 = in_q.d2;
    next_in_q.c1 = {i_queue_reset_n, i_write_en_n, i_read_en_n, i_output_en_n,
                    i_load_select_n, i_retransmit, i_sync_flag_mode};
    next_in_q.c2 = in_q.c1;
    next_in_q.c3 = in_q.c2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      in_q <= '0;
    end else begin
      in_q <= next_in_q;
    end
  end

  logic qrst_n, wen_n, ren_n, oe_n, ld_n, rt, sync_flag_mode;
  // c3 is two flops past c1's capture; the edge strobe has the same lag
  assign qrst_n = in_q.c3[6];
  assign wen_n  = in_q.c3[5];
  assign ren_n  = in_q.c3[4];
  assign oe_n   = in_q.c3[3];
  assign ld_n   = in_q.c3[2];
  assign rt     = in_q.c3[1];
  assign sync_flag_mode  = in_q.c3[0];

  // state word: pointers, offsets, alternation slots, output register,
  // output enables, the five flags and the sampled queue reset level
  // from the previous cycle, used to find the first cycle of a reset
  typedef struct packed {
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;
    logic [TW-1:0]    thr_e;
    logic [TW-1:0]    thr_f;
    logic             wsel;
    logic             rsel;
    logic [WIDTH-1:0] q;
    logic [WIDTH-1:0] oe_vec;
    logic             ef_n;
    logic             ff_n;
    logic             hf_n;
    logic             pae_n;
    logic             paf_n;
    logic             rst_prev;
  } dcf_st_t;
  dcf_st_t st, next_st;

  logic [AW:0]   wr_cnt;
  logic [AW:0]   rd_cnt;
  logic [AW:0]   n_wptr;
  logic [AW:0]   n_rptr;
  logic          do_wr;
  logic          do_rd;
  logic          rst_act;
  logic          ae_now;
  logic          af_now;
  logic          hf_now;

  //
  // occupancy after the moves of this cycle, so that the flags set on a
  // port edge already include the word that edge wrote or read
  // wr_cnt and rd_cnt are the same count; the two names keep the write
  // side and the read side decode readable
  // retransmit jumps the read pointer to the first location; the
  // write pointer is left alone, so the whole written history replays
  //
  // occupancy as seen after this cycle's pointer moves
  always_comb begin
    rst_act = !qrst_n;
    do_wr   = wr_e.rise && !wen_n && ld_n && st.ff_n && !rst_act;
    do_rd   = rd_e.rise && !ren_n && ld_n && st.ef_n && !rst_act;
    n_wptr  = do_wr ? st.wptr + (AW+1)'(1) : st.wptr;
    n_rptr  = do_rd ? st.rptr + (AW+1)'(1) : st.rptr;
    if (rt && !rst_act) begin
      n_rptr = '0;
    end
    wr_cnt  = n_wptr - n_rptr;
    rd_cnt  = wr_cnt;
    ae_now  = rd_cnt <= (AW+1)'(st.thr_e);
    af_now  = wr_cnt >= FULLC - (AW+1)'(st.thr_f);
    hf_now  = wr_cnt > HALF;
  end

  //
  // update order inside one i_clk cycle:
  //   pointers move first, from the aligned strobes and enables
  //   threshold access is decoded next; it never moves a pointer
  //   output register takes a stored word or a threshold value
  //   threshold read and stored word read cannot meet: one needs the
  //   load pin low and the other high
  //   full follows write edges and empty read edges, or a retransmit
  //   half full follows the occupancy on every cycle
  //   almost flags follow their own port edge, or every cycle when
  //   the flag mode pin is high
  //   retransmit refreshes every flag in the cycle it is seen, as the
  //   read pointer jump can change the occupancy by up to the depth
  //   queue reset wins over all of the above
  //
  // main queue state; reset of the queue itself comes from its own pin
  always_comb begin
    next_st          = st;
    next_st.rst_prev = qrst_n;
    next_st.wptr     = n_wptr;
    next_st.rptr     = n_rptr;
    // threshold programming, alternating empty then full
    if (wr_e.rise && !wen_n && !ld_n && !rst_act) begin
      if (st.wsel == 1'(dcf_pkg::DCF_THR_EMPTY)) begin
        next_st.thr_e = i_q_thr();
      end else begin
        next_st.thr_f = i_q_thr();
      end
      next_st.wsel = ~st.wsel;
    end
    if (rd_e.rise && !ren_n && !ld_n && !rst_act) begin
      next_st.q    = '0;
      next_st.q[TW-1:0] = (st.rsel == 1'(dcf_pkg::DCF_THR_EMPTY)) ? st.thr_e : st.thr_f;
      next_st.rsel = ~st.rsel;
    end
    if (do_rd) begin
      next_st.q = mem[st.rptr[AW-1:0]];
    end
    // full tracks write edges, empty read edges; retransmit updates both
    if (wr_e.rise || rt) begin
      next_st.ff_n = !(wr_cnt == FULLC);
    end
    if (rd_e.rise || rt) begin
      next_st.ef_n = !(rd_cnt == '0);
    end
    next_st.hf_n = !hf_now;
    // sync mode low: almost flags move only on their own port edge or a retransmit
    if (sync_flag_mode || wr_e.rise || rt) begin
      next_st.paf_n = !af_now;
    end
    if (sync_flag_mode || rd_e.rise || rt) begin
      next_st.pae_n = !ae_now;
    end
    // standalone part always holds read permission, so oe alone decides
    next_st.oe_vec = {WIDTH{oe_n}};
    if (rst_act) begin
      next_st.wptr  = '0;
      next_st.rptr  = '0;
      next_st.wsel  = 1'(dcf_pkg::DCF_THR_EMPTY);
      next_st.rsel  = 1'(dcf_pkg::DCF_THR_EMPTY);
      next_st.ef_n  = 1'b0;
      next_st.ff_n  = 1'b1;
      next_st.hf_n  = 1'b1;
      next_st.pae_n = 1'b0;
      next_st.paf_n = 1'b1;
      if (st.rst_prev) begin
        next_st.thr_e = THR_DEF;
        next_st.thr_f = THR_DEF;
        next_st.q     = WIDTH'(dcf_pkg::DCF_DATA_RST);
      end
    end
  end

  // offsets use only the low input bits; the upper bits are ignored
  // on load and read back as zero
  // threshold field of the aligned input word
  function automatic logic [TW-1:0] i_q_thr();
    return in_q.d3[TW-1:0];
  endfunction : i_q_thr

  // system reset loads the first-cycle queue reset state, default offsets included, and floats
  // the outputs; they are driven from the next cycle, as the aligned enable bit reads low until the pin arrives
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st          <= '0;
      st.thr_e    <= THR_DEF;
      st.thr_f    <= THR_DEF;
      st.ff_n     <= 1'b1;
      st.hf_n     <= 1'b1;
      st.paf_n    <= 1'b1;
      st.oe_vec   <= '1;
    end else begin
      st <= next_st;
    end
  end

  // storage write uses the aligned data word; refused writes leave
  // the array untouched, so a full queue keeps its oldest words
  // storage write
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[st.wptr[AW-1:0]] <= in_q.d3;
    end
  end

  // every output is a register bit of the state word
  // active-low flags keep their polarity from the pins all the way out
  assign o_read_data                = st.q;
  assign o_read_data_oe_n           = st.oe_vec;
  assign o_empty_indicator_n        = st.ef_n;
  assign o_full_indicator_n         = st.ff_n;
  assign o_half_full_indicator_n    = st.hf_n;
  assign o_almost_empty_indicator_n = st.pae_n;
  assign o_almost_full_indicator_n  = st.paf_n;
endmodule : dcf_fifo

// file: hw/dcf_pkg.sv
// constants for the dual-clock 18-bit queue
// assumes a single system clock i_clk samples both port clocks
package dcf_pkg;
  localparam int DCF_WIDTH      = 18;
  localparam int DCF_DEPTH      = 512;
  localparam int DCF_THR_W      = 12;
  localparam int DCF_THR_SMALL  = 63;   // default offset at the smallest depth
  localparam int DCF_THR_LARGE  = 127;  // default offset at larger depths
  localparam int DCF_SMALL_DEP  = 512;
  localparam int DCF_THR_EMPTY  = 0;    // alternation slot for the empty offset
  localparam int DCF_THR_FULL   = 1;    // alternation slot for the full offset
  localparam logic [17:0] DCF_DATA_RST = 18'h00000;
endpackage : dcf_pkg

// file: hw/dcf_edge_if.sv
// carrier for a port clock synchroniser and its rising-edge strobe
// assumes the sampler and reader share i_clk
`timescale 1ns/1ps
interface dcf_edge_if;
  logic rise;  // one-cycle pulse per rising edge of the port clock
  logic lvl;   // synchronised level of the port clock
  modport src (output rise, output lvl);
  modport dst (input rise, input lvl);
endinterface : dcf_edge_if

// file: hw/dcf_edge_sync.sv
// two-flop synchroniser plus rising edge detector for one port clock
// assumes the port clock is much slower than i_clk
`timescale 1ns/1ps
module dcf_edge_sync (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  dcf_edge_if.src   e
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } dcf_es_t;
  dcf_es_t st, next_st;

  // first flop feeds only the second one
  always_comb begin
    next_st      = st;
    next_st.meta = i_async;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    next_st.rise = st.sync & ~st.prev;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign e.rise = st.rise;
  assign e.lvl  = st.prev;
endmodule : dcf_edge_sync

// file: bench/dcf_fifo_asserts.sv
// checker for the queue top: flag coherence, port edge timing, output enable
// assumes it is bound onto dcf_fifo and that port clocks are sampled on i_clk
`timescale 1ns/1ps
module dcf_fifo_asserts #(
  parameter int WIDTH = dcf_pkg::DCF_WIDTH
) (
  input wire logic             i_clk,
  input wire logic             i_rstn,
  input wire logic             i_queue_reset_n,
  input wire logic             i_write_clk,
  input wire logic             i_read_clk,
  input wire logic             i_output_en_n,
  input wire logic             i_retransmit,
  input wire logic             i_sync_flag_mode,
  input wire logic [WIDTH-1:0] o_read_data,
  input wire logic [WIDTH-1:0] o_read_data_oe_n,
  input wire logic             o_empty_indicator_n,
  input wire logic             o_full_indicator_n,
  input wire logic             o_half_full_indicator_n,
  input wire logic             o_almost_empty_indicator_n,
  input wire logic             o_almost_full_indicator_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [3:0] quiet;
  // flags may move without a port edge just after a queue reset or retransmit
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !i_queue_reset_n || i_retransmit || $changed(i_sync_flag_mode))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  property p_oe_float; $rose(i_output_en_n) |-> ##[1:5] &o_read_data_oe_n; endproperty
  a_oe_float: assert property (p_oe_float) else $error("outputs not floated");
  property p_oe_drive; $fell(i_output_en_n) |-> ##[1:5] !(|o_read_data_oe_n); endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("outputs not driven");
  property p_qreset; $fell(i_queue_reset_n) |-> ##[1:6] (!o_empty_indicator_n &&
    !o_almost_empty_indicator_n && o_full_indicator_n && !(|o_read_data)); endproperty
  a_qreset: assert property (p_qreset) else $error("queue reset state wrong");
  property p_full; !o_full_indicator_n |-> o_empty_indicator_n && !o_almost_full_indicator_n;
  endproperty
  a_full: assert property (p_full) else $error("full flag incoherent");
  property p_half; !o_full_indicator_n |-> !o_half_full_indicator_n; endproperty
  a_half: assert property (p_half) else $error("half flag incoherent");
  property p_empty; !o_empty_indicator_n |-> !o_almost_empty_indicator_n; endproperty
  a_empty: assert property (p_empty) else $error("empty flag incoherent");
  property p_ef_edge; $changed(o_empty_indicator_n) |->
    $past(i_read_clk, 4) || $past(i_read_clk, 5) || quiet < 4'hc; endproperty
  a_ef_edge: assert property (p_ef_edge) else $error("empty moved off read edge");
  property p_ff_edge; $changed(o_full_indicator_n) |->
    $past(i_write_clk, 4) || $past(i_write_clk, 5) || quiet < 4'hc; endproperty
  a_ff_edge: assert property (p_ff_edge) else $error("full moved off write edge");
  property p_ae_edge; !i_sync_flag_mode && $changed(o_almost_empty_indicator_n) |->
    $past(i_read_clk, 4) || $past(i_read_clk, 5) || quiet < 4'hc; endproperty
  a_ae_edge: assert property (p_ae_edge) else $error("almost empty off read edge");
endmodule : dcf_fifo_asserts
bind dcf_fifo dcf_fifo_asserts #(.WIDTH(WIDTH)) u_chk (.*);

// file: bench/dcf_port_model.sv
// producer and consumer clocks for the queue ports, 64 ns each, offset phases
// assumes the bench drives enables and data while the clocks are low
`timescale 1ns/1ps
module dcf_port_model (
  input  wire logic i_stop,
  output logic      o_write_clk,
  output logic      o_read_clk
);
  // free running; both park low while stopped, around a retransmit pulse
  initial begin
    o_write_clk = 1'b0;
    o_read_clk  = 1'b0;
    #3;
    forever begin
      #16 o_write_clk = !i_stop && !o_write_clk;
      #16 o_read_clk  = !i_stop && !o_read_clk;
    end
  end
endmodule : dcf_port_model

// file: bench/dcf_fifo_tb.sv
// bench for the queue: thresholds, fill to refusal, drain, retransmit, resets
// assumes dcf_port_model makes the port clocks and the checker is bound
`timescale 1ns/1ps
module dcf_fifo_tb;
  logic        clk = 1'b0, rstn = 1'b0, qrst_n = 1'b0, wen_n = 1'b1, ren_n = 1'b1;
  logic        ld_n = 1'b1, oe_n = 1'b0, rt = 1'b0, sync_flag_mode = 1'b0, stop = 1'b0;
  logic        ws = 1'b0, rs = 1'b0, wclk, rclk, ef_n, ff_n, hf_n, ae_n, af_n;
  logic [17:0] din = 18'h00000, q, q_oe_n, last, hist [512], exp_q [$];
  logic [11:0] thr_e = 12'h03f, thr_f = 12'h03f;
  int          n_mismatch = 0, checked = 0, wi = 0, ri = 0, tv [4] = '{5, 9, 7, 20};
  initial forever #4 clk = ~clk;
  dcf_port_model u_port (.i_stop(stop), .o_write_clk(wclk), .o_read_clk(rclk));
  dcf_fifo dut (.i_clk(clk), .i_rstn(rstn), .i_queue_reset_n(qrst_n), .i_write_clk(wclk),
    .i_read_clk(rclk), .i_write_en_n(wen_n), .i_read_en_n(ren_n), .i_output_en_n(oe_n),
    .i_load_select_n(ld_n), .i_retransmit(rt), .i_sync_flag_mode(sync_flag_mode), .i_write_data(din),
    .o_read_data(q), .o_read_data_oe_n(q_oe_n), .o_empty_indicator_n(ef_n),
    .o_full_indicator_n(ff_n), .o_half_full_indicator_n(hf_n),
    .o_almost_empty_indicator_n(ae_n), .o_almost_full_indicator_n(af_n));
  task automatic chk(string nm, logic [17:0] e, logic [17:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // expected flags from the modelled occupancy
  task automatic flags;
    int c;
    c = wi - ri;
    chk("flags", {13'h0000, c != 512, c < 512 - thr_f, c <= 256, c > thr_e, c != 0},
      {13'h0000, ff_n, af_n, hf_n, ae_n, ef_n});
  endtask : flags
  // one port cycle: set up while the port clock is low, release after its rise
  task automatic op(logic w, logic r, logic ld, logic [17:0] d);
    if (w) @(negedge wclk);
    else @(negedge rclk);
    @(negedge clk);
    wen_n <= !w;
    ren_n <= !r;
    ld_n  <= !ld;
    din   <= d;
    if (r && ld) begin
      exp_q.push_back({6'h00, rs ? thr_f : thr_e});
      rs = !rs;
    end else if (r && wi > ri) begin
      exp_q.push_back(hist[ri]);
      ri++;
    end
    if (w && ld) begin
      if (ws) thr_f = d[11:0];
      else thr_e = d[11:0];
      ws = !ws;
    end else if (w && wi < 512) begin
      hist[wi] = d;
      wi++;
    end
    if (w) @(negedge wclk);
    else @(negedge rclk);
    @(negedge clk);
    wen_n <= 1'b1;
    ren_n <= 1'b1;
    ld_n  <= 1'b1;
    repeat (12) @(negedge clk);
    flags;
  endtask : op
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // scoreboard: oldest note against the output after each read edge
  initial forever begin
    wait (exp_q.size() > 0);
    @(posedge rclk);
    repeat (6) @(negedge clk);
    chk("read data", exp_q[0], q);
    last = exp_q.pop_front();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    void'($urandom(92));
    repeat (2) @(negedge clk);
    rstn <= 1'b1;
    repeat (6) @(negedge clk);
    qrst_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk("data", 18'h00000, q);
    flags;
    repeat (2) op(1'b0, 1'b1, 1'b1, 18'h00000);
    foreach (tv[i]) op(1'b1, 1'b0, 1'b1, {6'h2a, 12'(tv[i])});
    repeat (2) op(1'b0, 1'b1, 1'b1, 18'h00000);
    $display("thresholds done");
    repeat (513) op(1'b1, 1'b0, 1'b0, 18'($urandom));
    $display("fill done");
    sync_flag_mode <= 1'b1;
    repeat (513) op(1'b0, 1'b1, 1'b0, 18'h00000);
    chk("held data", last, q);
    $display("drain done");
    sync_flag_mode <= 1'b0;
    stop <= 1'b1;
    repeat (8) @(negedge clk);
    rt <= 1'b1;
    repeat (2) @(negedge clk);
    rt <= 1'b0;
    ri = 0;
    repeat (8) @(negedge clk);
    stop <= 1'b0;
    repeat (3) op(1'b0, 1'b1, 1'b0, 18'h00000);
    $display("retransmit done");
    oe_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk("float", 18'h3ffff, q_oe_n);
    oe_n <= 1'b0;
    qrst_n <= 1'b0;
    repeat (8) @(negedge clk);
    qrst_n <= 1'b1;
    {wi, ri, thr_e, thr_f, ws, rs} = {32'd0, 32'd0, 12'h03f, 12'h03f, 2'b00};
    repeat (8) @(negedge clk);
    flags;
    chk("reset data", 18'h00000, q);
    $display("resets done");
    end_of_test;
  end
endmodule : dcf_fifo_tb
